// >>> design/ccl_pkg.sv
package ccl_pkg;

  // Register indices as printed; byte address is four times the index
  localparam logic [7:0]  CCL_AUX_IDX  = 8'h1e;
  localparam logic [7:0]  CCL_CSR_IDX  = 8'h1f;
  localparam logic [9:0]  CCL_AUX_ADDR = {CCL_AUX_IDX, 2'b00};
  localparam logic [9:0]  CCL_CSR_ADDR = {CCL_CSR_IDX, 2'b00};
  localparam int          CCL_DEC_W    = 10;

  // comparator_control_status fields
  localparam int CCL_DIS_BIT  = 7;
  localparam int CCL_BG_BIT   = 6;
  localparam int CCL_RES_BIT  = 5;
  localparam int CCL_FLAG_BIT = 4;
  localparam int CCL_IE_BIT   = 3;
  localparam int CCL_CAP_BIT  = 2;
  localparam int CCL_MODEH_BIT = 1;
  localparam int CCL_MODEL_BIT = 0;

  // comparator_aux_control fields
  localparam int CCL_OE_BIT   = 1;
  localparam int CCL_PSEL_BIT = 0;

  localparam logic [7:0] CCL_CSR_RST = 8'h00;
  localparam logic [7:0] CCL_AUX_RST = 8'h00;

  // Interrupt mode encodings
  localparam logic [1:0] CCL_MODE_TOGGLE = 2'h0;
  localparam logic [1:0] CCL_MODE_RSVD   = 2'h1;
  localparam logic [1:0] CCL_MODE_FALL   = 2'h2;
  localparam logic [1:0] CCL_MODE_RISE   = 2'h3;

  // Synchroniser depth for the raw comparator output
  localparam int CCL_SYNC_STAGES = 2;

  // AHB-Lite codes
  localparam logic [1:0] CCL_HTRANS_NONSEQ = 2'h2;
  localparam logic       CCL_HRESP_OKAY    = 1'b0;

endpackage : ccl_pkg

// >>> design/ccl_sync.sv
`timescale 1ns/1ps
module ccl_sync
  import ccl_pkg::*;
#(
  parameter int STAGES = CCL_SYNC_STAGES
)(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic async_in,
  output logic      sync_out
);

  typedef struct packed {
    logic [STAGES-1:0] chain;
  } ccl_sync_state_t;

  ccl_sync_state_t state_ff;
  ccl_sync_state_t nxt_state;

  if (STAGES < 2)
  begin : g_check
    $error("ccl_sync needs at least two stages");
  end

  always_comb
  begin
    nxt_state       = state_ff;
    nxt_state.chain = {state_ff.chain[STAGES-2:0], async_in};
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign sync_out = state_ff.chain[STAGES-1];

endmodule : ccl_sync

// >>> design/ccl_edge.sv
`timescale 1ns/1ps
module ccl_edge
  import ccl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       level,
  input  wire logic [1:0] mode,
  output logic            event_pulse
);

  typedef struct packed {
    logic prev;
  } ccl_edge_state_t;

  ccl_edge_state_t state_ff;
  ccl_edge_state_t nxt_state;
  logic            rise;
  logic            fall;

  function automatic logic mode_match(input logic [1:0] m,
                                      input logic       r,
                                      input logic       f);
    logic hit;
    hit = 1'b0;
    case (m)
      CCL_MODE_TOGGLE: hit = r | f;
      CCL_MODE_FALL:   hit = f;
      CCL_MODE_RISE:   hit = r;
      default:         hit = 1'b0;
    endcase
    return hit;
  endfunction : mode_match

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.prev = level;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  // One pulse per change of the synchronised level that the mode selects; none in the reserved mode
  assign rise        = level & ~state_ff.prev;
  assign fall        = ~level & state_ff.prev;
  assign event_pulse = mode_match(mode, rise, fall);

endmodule : ccl_edge

// >>> design/ccl_top.sv
// What this block does
// - Result bit is high while positive input exceeds negative input.
// - Raw comparator output is synchronised, one to two cycles latency.
// - Disable control at bit 7 powers the comparator down, any time.
// - Bandgap enable turns reference on; it feeds positive input only if selected.
// - Positive select zero connects the positive input pin.
// - Flag bit 4 is set when a synchronised event matches the mode.
// - Flag clears when the processor executes the comparator vector.
// - Writing one to the flag clears it; writing zero leaves it.
// - Interrupt requested only with flag, enable bit 3 and global enable set.
// - Mode 00 toggle, 01 reserved, 10 falling, 11 rising.
// - Capture route bit 2 feeds the result to timer capture, else nothing.
// - Output enable bit 1 drives the result onto the result pin.
// - Shared converter multiplexer usable only while power reduction is zero.
`timescale 1ns/1ps
module ccl_top
  import ccl_pkg::*;
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        cmp_raw_in,
  input  wire logic        global_irq_enable,
  input  wire logic        irq_vector_ack,
  input  wire logic        converter_power_reduction,
  output logic             comparator_power_down,
  output logic             bandgap_on,
  output logic             bandgap_to_positive,
  output logic             mux_access_enable,
  output logic             capture_trigger,
  output logic             result_pin_out,
  output logic             result_pin_oe,
  output logic             comparator_irq
);

  typedef struct packed {
    logic        comparator_disable;
    logic        bandgap_enable;
    logic        comparator_irq_flag;
    logic        comparator_irq_enable;
    logic        capture_route_enable;
    logic        irq_mode_high;
    logic        irq_mode_low;
    logic        result_pin_enable;
    logic        positive_input_select;
    logic        dp_valid;
    logic        dp_write;
    logic        dp_csr;
    logic        dp_aux;
    logic [31:0] rdata;
  } ccl_state_t;

  ccl_state_t  state_ff;
  ccl_state_t  nxt_state;
  logic        comparator_result;
  logic        cmp_event;
  logic        addr_phase;
  logic        addr_csr;
  logic        addr_aux;
  logic        wr_csr;
  logic        wr_aux;
  logic        flag_clear;
  logic [7:0]  wbyte;

  // Exact byte-address decode on the low ten address bits
  function automatic logic addr_hit(input logic [31:0] a,
                                    input logic [9:0]  target);
    return a[CCL_DEC_W-1:0] == target;
  endfunction : addr_hit

  function automatic logic [7:0] pack_csr(input ccl_state_t s,
                                          input logic       res);
    logic [7:0] v;
    v                = 8'h00;
    v[CCL_DIS_BIT]   = s.comparator_disable;
    v[CCL_BG_BIT]    = s.bandgap_enable;
    v[CCL_RES_BIT]   = res;
    v[CCL_FLAG_BIT]  = s.comparator_irq_flag;
    v[CCL_IE_BIT]    = s.comparator_irq_enable;
    v[CCL_CAP_BIT]   = s.capture_route_enable;
    v[CCL_MODEH_BIT] = s.irq_mode_high;
    v[CCL_MODEL_BIT] = s.irq_mode_low;
    return v;
  endfunction : pack_csr

  function automatic logic [7:0] pack_aux(input ccl_state_t s);
    logic [7:0] v;
    v               = 8'h00;
    v[CCL_OE_BIT]   = s.result_pin_enable;
    v[CCL_PSEL_BIT] = s.positive_input_select;
    return v;
  endfunction : pack_aux

  // Raw comparator output arrives from the analog core, unclocked
  ccl_sync #(
    .STAGES   (CCL_SYNC_STAGES)
  ) u_sync (
    .clk      (hclk),
    .rst_n    (hresetn),
    .async_in (cmp_raw_in),
    .sync_out (comparator_result)
  );

  ccl_edge u_edge (
    .clk         (hclk),
    .rst_n       (hresetn),
    .level       (comparator_result),
    .mode        ({state_ff.irq_mode_high, state_ff.irq_mode_low}),
    .event_pulse (cmp_event)
  );

  // Bus decode
  assign addr_phase = hsel & hready & (htrans == CCL_HTRANS_NONSEQ || htrans[1]);
  assign addr_csr   = addr_hit(haddr, CCL_CSR_ADDR);
  assign addr_aux   = addr_hit(haddr, CCL_AUX_ADDR);
  assign wr_csr     = state_ff.dp_valid & state_ff.dp_write & state_ff.dp_csr;
  assign wr_aux     = state_ff.dp_valid & state_ff.dp_write & state_ff.dp_aux;
  assign wbyte      = hwdata[7:0];
  assign flag_clear = (wr_csr & wbyte[CCL_FLAG_BIT]) | irq_vector_ack;

  always_comb
  begin
    nxt_state          = state_ff;
    nxt_state.dp_valid = 1'b0;

    if (wr_csr)
    begin
      nxt_state.comparator_disable    = wbyte[CCL_DIS_BIT];
      nxt_state.bandgap_enable        = wbyte[CCL_BG_BIT];
      nxt_state.comparator_irq_enable = wbyte[CCL_IE_BIT];
      nxt_state.capture_route_enable  = wbyte[CCL_CAP_BIT];
      nxt_state.irq_mode_high         = wbyte[CCL_MODEH_BIT];
      nxt_state.irq_mode_low          = wbyte[CCL_MODEL_BIT];
      // Result position is ignored on write
    end

    if (wr_aux)
    begin
      nxt_state.result_pin_enable     = wbyte[CCL_OE_BIT];
      nxt_state.positive_input_select = wbyte[CCL_PSEL_BIT];
    end

    // Hardware set wins over any clear in the same cycle
    if (cmp_event)
      nxt_state.comparator_irq_flag = 1'b1;
    else if (flag_clear)
      nxt_state.comparator_irq_flag = 1'b0;

    if (addr_phase)
    begin
      nxt_state.dp_valid = 1'b1;
      nxt_state.dp_write = hwrite;
      nxt_state.dp_csr   = addr_csr;
      nxt_state.dp_aux   = addr_aux;
      // Read sees any write finishing this cycle
      if (!hwrite)
      begin
        if (addr_csr)
          nxt_state.rdata = {24'h000000, pack_csr(nxt_state, comparator_result)};
        else if (addr_aux)
          nxt_state.rdata = {24'h000000, pack_aux(nxt_state)};
        else
          nxt_state.rdata = 32'h00000000;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff                       <= '0;
      state_ff.comparator_disable    <= CCL_CSR_RST[CCL_DIS_BIT];
      state_ff.bandgap_enable        <= CCL_CSR_RST[CCL_BG_BIT];
      state_ff.comparator_irq_flag   <= CCL_CSR_RST[CCL_FLAG_BIT];
      state_ff.comparator_irq_enable <= CCL_CSR_RST[CCL_IE_BIT];
      state_ff.capture_route_enable  <= CCL_CSR_RST[CCL_CAP_BIT];
      state_ff.irq_mode_high         <= CCL_CSR_RST[CCL_MODEH_BIT];
      state_ff.irq_mode_low          <= CCL_CSR_RST[CCL_MODEL_BIT];
      state_ff.result_pin_enable     <= CCL_AUX_RST[CCL_OE_BIT];
      state_ff.positive_input_select <= CCL_AUX_RST[CCL_PSEL_BIT];
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  // Zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = CCL_HRESP_OKAY;
  assign hrdata    = state_ff.rdata;

  // Analog controls
  assign comparator_power_down = state_ff.comparator_disable;
  assign bandgap_on            = state_ff.bandgap_enable;
  // Pin when select is zero, bandgap only when both set
  assign bandgap_to_positive   = state_ff.bandgap_enable
                               & state_ff.positive_input_select;
  assign mux_access_enable     = ~converter_power_reduction;

  // Timer capture route and result pin
  assign capture_trigger = state_ff.capture_route_enable & comparator_result;
  assign result_pin_out  = comparator_result;
  assign result_pin_oe   = state_ff.result_pin_enable;

  assign comparator_irq = state_ff.comparator_irq_flag
                        & state_ff.comparator_irq_enable
                        & global_irq_enable;

endmodule : ccl_top

// >>> verif/ccl_cmp_model.sv
`timescale 1ns/1ps
module ccl_cmp_model
  import ccl_pkg::*;
#(
  parameter logic [11:0] BG_MV = 12'h44c
)(
  input  wire logic [11:0] pos_pin_mv,
  input  wire logic [11:0] neg_pin_mv,
  input  wire logic        power_down,
  input  wire logic        bandgap_on,
  input  wire logic        bandgap_to_positive,
  output logic             raw_out
);
  logic [11:0] pos_eff;

  // Reference only present when powered; unpowered reference reads as ground
  assign pos_eff = bandgap_to_positive ? (bandgap_on ? BG_MV : 12'h000)
                                       : pos_pin_mv;
  assign raw_out = !power_down && (pos_eff > neg_pin_mv);
endmodule : ccl_cmp_model

// >>> verif/ccl_top_monitor.sv
`timescale 1ns/1ps
module ccl_monitor
  import ccl_pkg::*;
(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        cmp_raw_in,
  input wire logic        global_irq_enable,
  input wire logic        irq_vector_ack,
  input wire logic        converter_power_reduction,
  input wire logic        comparator_power_down,
  input wire logic        bandgap_on,
  input wire logic        bandgap_to_positive,
  input wire logic        mux_access_enable,
  input wire logic        capture_trigger,
  input wire logic        result_pin_out,
  input wire logic        result_pin_oe,
  input wire logic        comparator_irq
);
  logic take;
  logic wr_csr_ff;
  logic wr_aux_ff;

  assign take = hsel && hready && htrans[1] && hwrite;

  // Marks the data phase of a register write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_csr_ff <= 1'b0;
      wr_aux_ff <= 1'b0;
    end
    else
    begin
      wr_csr_ff <= take && (haddr[9:0] == CCL_CSR_ADDR);
      wr_aux_ff <= take && (haddr[9:0] == CCL_AUX_ADDR);
    end
  end

  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);

  chk_mux_gate: assert property (
    mux_access_enable == !converter_power_reduction) else $error("mux access wrong");
  chk_sync_delay: assert property (
    $past(hresetn) && $past(hresetn, 2) |-> result_pin_out == $past(cmp_raw_in, 2))
    else $error("result not two cycles behind raw");
  chk_capture_route: assert property (
    capture_trigger |-> result_pin_out) else $error("capture without result");
  chk_bg_select: assert property (
    bandgap_to_positive |-> bandgap_on) else $error("reference selected while off");
  chk_disable_write: assert property (
    wr_csr_ff |=> comparator_power_down == $past(hwdata[CCL_DIS_BIT]))
    else $error("disable bit not applied");
  chk_bg_write: assert property (
    wr_csr_ff |=> bandgap_on == $past(hwdata[CCL_BG_BIT])) else $error("bandgap bit not applied");
  chk_pin_enable: assert property (
    wr_aux_ff |=> result_pin_oe == $past(hwdata[CCL_OE_BIT])) else $error("pin enable not applied");
  chk_vector_clear: assert property (
    irq_vector_ack && $stable(result_pin_out) |=> !comparator_irq)
    else $error("vector did not clear flag");
  chk_flag_w1c: assert property (
    wr_csr_ff && hwdata[CCL_FLAG_BIT] && $stable(result_pin_out) |=> !comparator_irq)
    else $error("write one did not clear flag");
  chk_irq_gate: assert property (
    !global_irq_enable |-> !comparator_irq) else $error("request without global enable");

  cov_irq: cover property ($rose(comparator_irq));
  cov_aux: cover property (wr_aux_ff);
  cov_capture: cover property ($rose(capture_trigger));
endmodule : ccl_monitor

bind ccl_top ccl_monitor u_mon (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .hready, .cmp_raw_in, .global_irq_enable, .irq_vector_ack, .converter_power_reduction,
  .comparator_power_down, .bandgap_on, .bandgap_to_positive, .mux_access_enable,
  .capture_trigger, .result_pin_out, .result_pin_oe, .comparator_irq);

// >>> verif/test_comparator_control_logic.sv
`timescale 1ns/1ps
module test_comparator_control_logic;
  import ccl_pkg::*;
  typedef struct packed {
    logic [1:0] mode;
    logic       start_hi;
    logic       end_hi;
    logic       exp_flag;
  } ccl_row_t;

  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, cmp_raw_in;
  logic        global_irq_enable, irq_vector_ack, converter_power_reduction;
  logic        comparator_power_down, bandgap_on, bandgap_to_positive, mux_access_enable;
  logic        capture_trigger, result_pin_out, result_pin_oe, comparator_irq;
  logic [1:0]  htrans;
  logic [11:0] pos_mv, neg_mv;
  logic [31:0] haddr, hwdata, hrdata, rd;
  int          n_mismatch, n_compared;
  ccl_row_t    rows [7] = '{'{CCL_MODE_TOGGLE, 1'b0, 1'b1, 1'b1},
                            '{CCL_MODE_TOGGLE, 1'b1, 1'b0, 1'b1},
                            '{CCL_MODE_RSVD,   1'b0, 1'b1, 1'b0},
                            '{CCL_MODE_FALL,   1'b1, 1'b0, 1'b1},
                            '{CCL_MODE_FALL,   1'b0, 1'b1, 1'b0},
                            '{CCL_MODE_RISE,   1'b0, 1'b1, 1'b1},
                            '{CCL_MODE_RISE,   1'b1, 1'b0, 1'b0}};

  ccl_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .cmp_raw_in, .global_irq_enable,
    .irq_vector_ack, .converter_power_reduction, .comparator_power_down, .bandgap_on,
    .bandgap_to_positive, .mux_access_enable, .capture_trigger, .result_pin_out,
    .result_pin_oe, .comparator_irq);
  ccl_cmp_model u_cmp (.pos_pin_mv(pos_mv), .neg_pin_mv(neg_mv),
    .power_down(comparator_power_down), .bandgap_on, .bandgap_to_positive, .raw_out(cmp_raw_in));

  initial
  begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end

  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= CCL_HTRANS_NONSEQ;
    haddr <= {22'h0, a};
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic set_pos(input logic hi);
    @(posedge hclk);
    pos_mv <= hi ? 12'h5dc : 12'h1f4;
    repeat (5) @(posedge hclk);
  endtask : set_pos

  task automatic wrap_up();
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  initial
  begin
    repeat (5000) @(posedge hclk);
    n_mismatch++;
    wrap_up();
  end

  initial
  begin
    {hresetn, hsel, hwrite, global_irq_enable, irq_vector_ack, converter_power_reduction} = 6'h0;
    {haddr, hwdata, htrans} = '0;
    {n_mismatch, n_compared} = '0;
    pos_mv = 12'h1f4;
    neg_mv = 12'h3e8;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CCL_AUX_ADDR, 32'h0);
    chk(rd, {24'h0, CCL_AUX_RST});
    chk(hresp, {31'h0, CCL_HRESP_OKAY});
    bus(1'b1, CCL_CSR_ADDR, 32'h20);
    bus(1'b0, CCL_CSR_ADDR, 32'h0);
    chk(rd, {24'h0, CCL_CSR_RST});
    bus(1'b0, 10'h080, 32'h0);
    chk(rd, 32'h0);
    foreach (rows[i])
    begin
      set_pos(rows[i].start_hi);
      // Clears the flag left by the previous row
      bus(1'b1, CCL_CSR_ADDR, {27'h0, 1'b1, 2'h0, rows[i].mode});
      set_pos(rows[i].end_hi);
      bus(1'b0, CCL_CSR_ADDR, 32'h0);
      chk(rd, {26'h0, rows[i].end_hi, rows[i].exp_flag, 2'h0, rows[i].mode});
    end
    bus(1'b1, CCL_CSR_ADDR, 32'h0b);
    global_irq_enable <= 1'b1;
    set_pos(1'b1);
    chk(comparator_irq, 32'h1);
    global_irq_enable <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(comparator_irq, 32'h0);
    global_irq_enable <= 1'b1;
    irq_vector_ack <= 1'b1;
    @(posedge hclk);
    irq_vector_ack <= 1'b0;
    repeat (2) @(posedge hclk);
    chk(comparator_irq, 32'h0);
    set_pos(1'b0);
    set_pos(1'b1);
    bus(1'b1, CCL_CSR_ADDR, 32'h0b);
    chk(comparator_irq, 32'h1);
    bus(1'b1, CCL_CSR_ADDR, 32'h1b);
    @(posedge hclk);
    chk(comparator_irq, 32'h0);
    bus(1'b1, CCL_CSR_ADDR, 32'h40);
    set_pos(1'b0);
    bus(1'b1, CCL_AUX_ADDR, 32'h01);
    set_pos(1'b0);
    bus(1'b0, CCL_CSR_ADDR, 32'h0);
    // Toggle mode has flagged both moves of the result
    chk(rd, 32'h70);
    chk(bandgap_to_positive, 32'h1);
    bus(1'b1, CCL_AUX_ADDR, 32'h02);
    set_pos(1'b0);
    bus(1'b0, CCL_CSR_ADDR, 32'h0);
    chk(rd, 32'h50);
    chk(bandgap_to_positive, 32'h0);
    chk(result_pin_oe, 32'h1);
    bus(1'b1, CCL_CSR_ADDR, 32'h04);
    set_pos(1'b1);
    chk(capture_trigger, 32'h1);
    chk(result_pin_out, 32'h1);
    bus(1'b1, CCL_CSR_ADDR, 32'h84);
    set_pos(1'b1);
    chk(comparator_power_down, 32'h1);
    chk(capture_trigger, 32'h0);
    converter_power_reduction <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(mux_access_enable, 32'h0);
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    bus(1'b0, CCL_CSR_ADDR, 32'h0);
    chk(rd, {24'h0, CCL_CSR_RST});
    wrap_up();
  end
endmodule : test_comparator_control_logic
